// file: logic/sra_port.sv
// Serial register port in four-wire mode with open-drain limit alert
// Function
// - Device is slave only; host supplies serial clock with data synchronous to it
// - Transfer opens with command word: 90h writes, 91h reads
// - Incoming serial data is sampled on rising serial clock edges
// - With chip select high, data input and output pins are high impedance
// - Serial input is ignored until chip select has fallen
// - Write: byte after command loads pointer, later bytes write pointed register
// - Pointer advances 00h to 3Fh then wraps to 00h, writes and reads
// - Host sets pointer by write, then reads; command byte sees meaningless output
// - Eight clocks after read command shift out the pointed register
// - Serial output changes on falling serial clock edges
// - Continued clocking advances pointer and shifts out the next register
// - Alert is open drain; polarity bit picks level, active low by default
// - Disable bit set to 1 turns alert off, 0 turns it on
// - Alert asserts when any monitored value leaves its upper or lower limit
// - Alert releases only when value is back in limits and status read
// - Alert causes are kept in two interrupt status registers
// - While alerting and not locked in SPI mode, answer alert response address with own address and LSB 1
// - Simultaneous alert responders arbitrate so lowest address wins
// - After answering, alert releases only once cleared and status read
// - Three chip select pulses select and lock SPI mode until power cycle
// - Registers are eight bits; one byte moves per register access
`timescale 1ns/100ps
`default_nettype none
module sra_port
   import sra_pkg::*;
#(
   parameter int STAT_REGS = SRA_STAT_REGS,
   parameter int EV_N      = SRA_REG_W * SRA_STAT_REGS
) (
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 resetn,
   // Serial pins, asynchronous to clk_sys
   input  wire sra_pins_t            spi_pins,
   output logic                      dout,
   output logic                      dout_oe,
   // Register file side
   output sra_reg_req_t              reg_req,
   input  wire logic [7:0]           reg_rdata,
   output logic                      spi_locked,
   // Limit events and interrupt status
   input  wire logic [EV_N-1:0]      limit_out,
   input  wire logic [STAT_REGS-1:0] status_rd,
   output logic [EV_N-1:0]           int_status,
   // Alert configuration and pin
   input  wire logic                 alert_polarity_bit,
   input  wire logic                 alert_disable_bit,
   output logic                      alert_out,
   output logic                      alert_oe,
   // Alert response from the two-wire front end
   input  wire logic [6:0]           dev_addr,
   input  wire logic                 ara_req,
   input  wire logic [6:0]           ara_rd_addr,
   input  wire logic                 ara_done,
   input  wire logic [6:0]           ara_bus_addr,
   output logic                      ara_ack,
   output logic [7:0]                ara_byte,
   output logic                      ara_won
);

   if (STAT_REGS < 1 || EV_N != SRA_REG_W * STAT_REGS) begin : g_chk
      $error("EV_N must be eight times STAT_REGS");
   end

   // Pin synchronisers; the third stage only serves edge detection
   sra_pins_t pin_m_q;
   sra_pins_t pin_s_q;
   sra_pins_t pin_p_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_m_q <= sra_pins_t'(SRA_PINS_IDLE);
         pin_s_q <= sra_pins_t'(SRA_PINS_IDLE);
         pin_p_q <= sra_pins_t'(SRA_PINS_IDLE);
      end else begin
         pin_m_q <= spi_pins;
         pin_s_q <= pin_m_q;
         pin_p_q <= pin_s_q;
      end
   end

   // Serial clock is sampled, never used as a clock
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   assign cs_fall  = pin_p_q.cs_n & ~pin_s_q.cs_n;
   assign cs_rise  = ~pin_p_q.cs_n & pin_s_q.cs_n;
   assign sck_rise = ~pin_p_q.sclk & pin_s_q.sclk;
   assign sck_fall = pin_p_q.sclk & ~pin_s_q.sclk;

   // Mode lock; only a power-on reset undoes it
   logic [1:0] lock_cnt_q;
   logic       locked_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         lock_cnt_q <= 2'h0;
         locked_q   <= 1'b0;
      end else if (cs_rise && !locked_q) begin
         lock_cnt_q <= lock_cnt_q + 2'h1;
         if (lock_cnt_q == SRA_LOCK_PULSES - 2'h1) begin
            locked_q <= 1'b1;
         end
      end
   end
   assign spi_locked = locked_q;

   // Frame is opened only by a falling chip select once locked
   logic active_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         active_q <= 1'b0;
      end else if (cs_rise) begin
         active_q <= 1'b0;
      end else if (cs_fall && locked_q) begin
         active_q <= 1'b1;
      end
   end
   // Data input is never driven; output floats outside a frame
   assign dout_oe = active_q;

   // Receiver
   logic [6:0] rx_q;
   logic [2:0] bit_q;
   logic       take;
   logic       byte_done;
   logic [7:0] rx_byte;
   assign take      = active_q & sck_rise;
   assign byte_done = take & (bit_q == SRA_BIT_LAST);
   assign rx_byte   = {rx_q, pin_s_q.din};

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rx_q  <= 7'h00;
         bit_q <= SRA_BIT_FIRST;
      end else if (cs_rise) begin
         bit_q <= SRA_BIT_FIRST;
      end else if (take) begin
         rx_q  <= rx_byte[6:0];
         bit_q <= bit_q + 3'h1;
      end
   end

   // Command decode and address pointer
   sra_state_t   state_q;
   logic [7:0]   ptr_q;
   logic [7:0]   ptr_next;
   sra_reg_req_t req_q;
   // A pointer loaded above the top also falls back to the bottom
   assign ptr_next = (ptr_q >= SRA_PTR_LAST) ? SRA_PTR_FIRST : ptr_q + 8'h01;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q <= SRA_ST_CMD;
         ptr_q   <= SRA_PTR_RESET;
         req_q   <= '0;
      end else begin
         req_q.wr <= 1'b0;
         req_q.rd <= 1'b0;
         if (cs_rise) begin
            state_q <= SRA_ST_CMD;
         end else if (byte_done) begin
            case (state_q)
               SRA_ST_CMD: begin
                  if (rx_byte == SRA_CMD_WRITE) begin
                     state_q <= SRA_ST_ADDR;
                  end else if (rx_byte == SRA_CMD_READ) begin
                     state_q    <= SRA_ST_RDATA;
                     req_q.rd   <= 1'b1;
                     req_q.addr <= ptr_q;
                     ptr_q      <= ptr_next;
                  end else begin
                     state_q <= SRA_ST_IGNORE;
                  end
               end
               SRA_ST_ADDR: begin
                  ptr_q   <= rx_byte;
                  state_q <= SRA_ST_WDATA;
               end
               SRA_ST_WDATA: begin
                  req_q.wr    <= 1'b1;
                  req_q.addr  <= ptr_q;
                  req_q.wdata <= rx_byte;
                  ptr_q       <= ptr_next;
               end
               SRA_ST_RDATA: begin
                  // Fetch ahead so the next byte is ready before its first falling edge
                  req_q.rd   <= 1'b1;
                  req_q.addr <= ptr_q;
                  ptr_q      <= ptr_next;
               end
               default: begin
                  state_q <= state_q;
               end
            endcase
         end
      end
   end
   assign reg_req = req_q;

   // Transmitter; read data arrives one clock after the fetch strobe
   logic       load_q;
   logic [7:0] tx_q;
   logic       dout_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         load_q <= 1'b0;
         tx_q   <= 8'h00;
         dout_q <= 1'b0;
      end else begin
         load_q <= req_q.rd;
         if (load_q) begin
            tx_q <= reg_rdata;
         end else if (active_q && sck_fall) begin
            tx_q <= {tx_q[6:0], 1'b0};
         end
         if (active_q && sck_fall) begin
            dout_q <= tx_q[7];
         end
      end
   end
   assign dout = dout_q;

   // Limit events: a new event wins over a clearing read
   logic [EV_N-1:0] flag_q;
   logic [EV_N-1:0] seen_q;
   logic [EV_N-1:0] rd_vec;

   for (genvar i = 0; i < EV_N; i++) begin : g_ev
      logic rd_i;
      assign rd_i = status_rd[i / SRA_REG_W];
      // Per-event view of the status reads, for the clearing check
      assign rd_vec[i] = rd_i;
      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            flag_q[i] <= 1'b0;
            seen_q[i] <= 1'b0;
         end else begin
            if (limit_out[i]) begin
               flag_q[i] <= 1'b1;
            end else if (flag_q[i] && (seen_q[i] || rd_i)) begin
               flag_q[i] <= 1'b0;
            end
            seen_q[i] <= flag_q[i] & (seen_q[i] | rd_i);
         end
      end
   end
   assign int_status = flag_q;

   // Open-drain alert: pull low for the low level of the chosen polarity
   logic alert_on;
   logic alert_oe_q;
   assign alert_on = (|flag_q) & ~alert_disable_bit;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         alert_oe_q <= 1'b0;
      end else begin
         alert_oe_q <= alert_polarity_bit ^ alert_on;
      end
   end
   assign alert_oe  = alert_oe_q;
   assign alert_out = 1'b0;

   // Alert response; wired-AND address bits let the lowest address survive
   logic       ara_ack_q;
   logic       ara_won_q;
   logic       ara_pend_q;
   logic [7:0] ara_byte_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ara_ack_q  <= 1'b0;
         ara_won_q  <= 1'b0;
         ara_pend_q <= 1'b0;
         ara_byte_q <= 8'h00;
      end else begin
         ara_ack_q <= 1'b0;
         ara_won_q <= 1'b0;
         if (ara_req && !locked_q && alert_on && ara_rd_addr == SRA_ARA_ADDR) begin
            ara_ack_q  <= 1'b1;
            ara_byte_q <= {dev_addr, SRA_ARA_LSB};
            ara_pend_q <= 1'b1;
         end else if (ara_done && ara_pend_q) begin
            ara_pend_q <= 1'b0;
            ara_won_q  <= (ara_bus_addr == dev_addr);
         end
      end
   end
   assign ara_ack  = ara_ack_q;
   assign ara_byte = ara_byte_q;
   assign ara_won  = ara_won_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_lock;
      cs_rise && !locked_q && lock_cnt_q == 2'h2 |=> locked_q;
   endproperty
   a_lock: assert property (p_lock) else $error("mode not locked on third pulse");

   property p_float;
      pin_s_q.cs_n && pin_p_q.cs_n |-> !dout_oe;
   endproperty
   a_float: assert property (p_float) else $error("output driven with chip select high");

   property p_ignore;
      !active_q && !$past(active_q) |-> !reg_req.wr && !reg_req.rd;
   endproperty
   a_ignore: assert property (p_ignore) else $error("access outside a frame");

   property p_write;
      byte_done && state_q == SRA_ST_WDATA
      |=> reg_req.wr && reg_req.wdata == $past(rx_byte) && reg_req.addr == $past(ptr_q);
   endproperty
   a_write: assert property (p_write) else $error("data byte not written to pointer");

   property p_wrap;
      byte_done && ptr_q == SRA_PTR_LAST && (state_q == SRA_ST_WDATA || state_q == SRA_ST_RDATA)
      |=> ptr_q == SRA_PTR_FIRST;
   endproperty
   a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

   property p_read;
      byte_done && state_q == SRA_ST_CMD && rx_byte == SRA_CMD_READ
      |=> reg_req.rd && state_q == SRA_ST_RDATA ##1 load_q;
   endproperty
   a_read: assert property (p_read) else $error("read command did not fetch");

   property p_dout;
      !$past(sck_fall) |-> $stable(dout);
   endproperty
   a_dout: assert property (p_dout) else $error("output changed off a falling edge");

   property p_next;
      byte_done && state_q == SRA_ST_RDATA |=> reg_req.rd && reg_req.addr == $past(ptr_q);
   endproperty
   a_next: assert property (p_next) else $error("burst read did not advance");

   property p_pol;
      $past(|flag_q) && !$past(alert_disable_bit) |-> alert_oe == !$past(alert_polarity_bit);
   endproperty
   a_pol: assert property (p_pol) else $error("alert level wrong for polarity");

   property p_dis;
      $past(alert_disable_bit) |-> alert_oe == $past(alert_polarity_bit);
   endproperty
   a_dis: assert property (p_dis) else $error("disabled alert still active");

   property p_set;
      limit_out != '0 |=> (int_status & $past(limit_out)) == $past(limit_out);
   endproperty
   a_set: assert property (p_set) else $error("limit event not recorded");

   property p_clr;
      1'b1 |=> ($past(flag_q) & ~flag_q & ($past(limit_out) | ~($past(seen_q) | $past(rd_vec)))) == '0;
   endproperty
   a_clr: assert property (p_clr) else $error("status cleared while out of limits");

   property p_ara;
      ara_req && !locked_q && alert_on && ara_rd_addr == SRA_ARA_ADDR
      |=> ara_ack && ara_byte == {$past(dev_addr), 1'b1};
   endproperty
   a_ara: assert property (p_ara) else $error("alert response not answered");

   property p_abort;
      cs_rise |=> state_q == SRA_ST_CMD && bit_q == SRA_BIT_FIRST;
   endproperty
   a_abort: assert property (p_abort) else $error("decoder not reset by chip select");

   c_write: cover property (reg_req.wr ##[1:300] reg_req.wr);
   c_burst: cover property (reg_req.rd ##[1:300] reg_req.rd);
   c_wrapped: cover property (byte_done && ptr_q == SRA_PTR_LAST && state_q == SRA_ST_RDATA);
   c_ara: cover property (ara_won);

endmodule
`default_nettype wire

// file: logic/sra_pkg.sv
// Constants and carrier types of the SPI register port with limit alert
`default_nettype none
package sra_pkg;

   // Command words
   localparam logic [7:0] SRA_CMD_WRITE   = 8'h90;
   localparam logic [7:0] SRA_CMD_READ    = 8'h91;

   // Address pointer range
   localparam logic [7:0] SRA_PTR_FIRST   = 8'h00;
   localparam logic [7:0] SRA_PTR_LAST    = 8'h3f;
   localparam logic [7:0] SRA_PTR_RESET   = 8'h00;

   // Framing
   localparam logic [1:0] SRA_LOCK_PULSES = 2'h3;
   localparam logic [2:0] SRA_BIT_FIRST   = 3'h0;
   localparam logic [2:0] SRA_BIT_LAST    = 3'h7;
   localparam int         SRA_REG_W       = 8;
   localparam int         SRA_STAT_REGS   = 2;

   // Alert response
   localparam logic [6:0] SRA_ARA_ADDR    = 7'h0c;
   localparam logic       SRA_ARA_LSB     = 1'b1;

   // Idle pin levels: chip select and clock high, data low
   localparam logic [2:0] SRA_PINS_IDLE   = 3'h6;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } sra_pins_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sra_reg_req_t;

   typedef enum logic [2:0] {
      SRA_ST_CMD,
      SRA_ST_ADDR,
      SRA_ST_WDATA,
      SRA_ST_RDATA,
      SRA_ST_IGNORE
   } sra_state_t;

endpackage
`default_nettype wire

// file: bench/sra_host.sv
// Host side model: drives chip select, serial clock and data, samples returned data
`timescale 1ns/100ps
`default_nettype none
module sra_host
   import sra_pkg::*;
(
   // Clock
   input  wire logic      clk_sys,
   // Pins toward the device
   output var  sra_pins_t pins,
   input  wire logic      dout,
   input  wire logic      dout_oe
);
   logic line;

   // Released output floats to the pull-up level
   assign line = (dout_oe === 1'b1) ? dout : 1'b1;

   initial pins = SRA_PINS_IDLE;

   // Idle data toggles so any input taken outside a frame would show up
   always @(posedge clk_sys) begin
      if (pins.cs_n) begin
         pins.din <= ~pins.din;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Chip select pulses that choose the serial mode
   task automatic lock(input int n);
      @(posedge clk_sys);
      repeat (n) begin
         pins.cs_n <= 1'b0;
         tick(4);
         pins.cs_n <= 1'b1;
         tick(4);
      end
   endtask

   task automatic frame_open();
      @(posedge clk_sys);
      pins.cs_n <= 1'b0;
      tick(4);
   endtask

   // Last rise is given time to land before chip select goes up
   task automatic frame_close();
      tick(4);
      pins.cs_n <= 1'b1;
      tick(8);
   endtask

   // Host owns the clock; data set at the fall, held through the rise, MSB first
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         pins.sclk <= 1'b0;
         pins.din  <= tx[i];
         tick(4);
         pins.sclk <= 1'b1;
         tick(4);
         rx[i] = line;
      end
   endtask
endmodule
`default_nettype wire

// file: bench/sra_port_tb.sv
// Self-checking bench of the serial register port with limit alert
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; $display("mismatch at %0t got %h expected %h", $time, (g), (e)); end end
module sra_port_tb
   import sra_pkg::*;
;
   logic         clk_sys, resetn, dout, dout_oe, spi_locked;
   sra_pins_t    spi_pins;
   sra_reg_req_t reg_req;
   logic [7:0]   reg_rdata, ara_byte, rx, r1, r2, r3;
   logic [15:0]  limit_out, int_status;
   logic [1:0]   status_rd;
   logic         alert_polarity_bit, alert_disable_bit, alert_out, alert_oe;
   logic [6:0]   dev_addr, ara_rd_addr, ara_bus_addr;
   logic         ara_req, ara_done, ara_ack, ara_won;
   logic [15:0]  wq[$];
   int           checks, bad_count, cycles, ack_cnt, won_cnt;

   sra_port dut (.clk_sys(clk_sys), .resetn(resetn), .spi_pins(spi_pins), .dout(dout), .dout_oe(dout_oe),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .spi_locked(spi_locked), .limit_out(limit_out),
      .status_rd(status_rd), .int_status(int_status), .alert_polarity_bit(alert_polarity_bit),
      .alert_disable_bit(alert_disable_bit), .alert_out(alert_out), .alert_oe(alert_oe),
      .dev_addr(dev_addr), .ara_req(ara_req), .ara_rd_addr(ara_rd_addr), .ara_done(ara_done),
      .ara_bus_addr(ara_bus_addr), .ara_ack(ara_ack), .ara_byte(ara_byte), .ara_won(ara_won));

   sra_host u_host (.clk_sys(clk_sys), .pins(spi_pins), .dout(dout), .dout_oe(dout_oe));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Register file stand-in: contents are a known function of the address
   always @(posedge clk_sys) begin
      if (reg_req.rd === 1'b1) begin
         reg_rdata <= reg_req.addr ^ 8'ha5;
      end
      if (reg_req.wr === 1'b1) begin
         wq.push_back({reg_req.addr, reg_req.wdata});
      end
      if (ara_ack === 1'b1) begin
         ack_cnt++;
      end
      if (ara_won === 1'b1) begin
         won_cnt++;
      end
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic ara_pulse(input logic [6:0] a, input logic is_done);
      if (is_done) begin
         ara_bus_addr <= a;
         ara_done     <= 1'b1;
      end else begin
         ara_rd_addr <= a;
         ara_req     <= 1'b1;
      end
      tick(1);
      ara_done <= 1'b0;
      ara_req  <= 1'b0;
      tick(3);
   endtask

   task automatic stat(input logic [1:0] s);
      status_rd <= s;
      tick(1);
      status_rd <= 2'b00;
      tick(3);
   endtask

   // Whole frame of up to three bytes; n counts the bits of the last byte
   task automatic frame(input logic [7:0] b0, b1, b2, input int nb, input int n);
      u_host.frame_open();
      u_host.xfer(b0, 8, rx);
      if (nb > 1) u_host.xfer(b1, (nb == 2) ? n : 8, rx);
      if (nb > 2) u_host.xfer(b2, n, rx);
      u_host.frame_close();
   endtask

   initial begin
      resetn = 1'b0;
      reg_rdata = 8'h00;
      limit_out = 16'h0000;
      status_rd = 2'b00;
      alert_polarity_bit = 1'b0;
      alert_disable_bit = 1'b0;
      dev_addr = 7'h4a;
      ara_req = 1'b0;
      ara_done = 1'b0;
      ara_rd_addr = 7'h00;
      ara_bus_addr = 7'h00;
      tick(2);
      resetn <= 1'b1;
      tick(2);
      `CHK(spi_locked, 1'b0)
      `CHK(dout_oe, 1'b0)
      `CHK(alert_oe, 1'b0)
      limit_out <= 16'h0008;
      tick(3);
      `CHK(int_status, 16'h0008)
      `CHK(alert_oe, 1'b1)
      `CHK(alert_out, 1'b0)
      limit_out <= 16'h0000;
      tick(4);
      `CHK(alert_oe, 1'b1)
      ara_pulse(7'h0d, 1'b0);
      `CHK(ack_cnt, 0)
      ara_pulse(SRA_ARA_ADDR, 1'b0);
      `CHK(ack_cnt, 1)
      `CHK(ara_byte, {dev_addr, SRA_ARA_LSB})
      ara_pulse(dev_addr - 7'h01, 1'b1);
      `CHK(won_cnt, 0)
      ara_pulse(SRA_ARA_ADDR, 1'b0);
      `CHK(ack_cnt, 2)
      ara_pulse(dev_addr, 1'b1);
      `CHK(won_cnt, 1)
      `CHK(alert_oe, 1'b1)
      stat(2'b10);
      `CHK(int_status, 16'h0008)
      stat(2'b01);
      `CHK(int_status, 16'h0000)
      `CHK(alert_oe, 1'b0)
      limit_out <= 16'h8000;
      alert_disable_bit <= 1'b1;
      tick(3);
      `CHK(int_status, 16'h8000)
      `CHK(alert_oe, 1'b0)
      alert_polarity_bit <= 1'b1;
      tick(3);
      `CHK(alert_oe, 1'b1)
      alert_disable_bit <= 1'b0;
      tick(3);
      `CHK(alert_oe, 1'b0)
      limit_out <= 16'h0000;
      alert_polarity_bit <= 1'b0;
      stat(2'b01);
      `CHK(int_status, 16'h8000)
      stat(2'b10);
      `CHK(int_status, 16'h0000)
      // Frame before the mode is locked counts as the first chip select pulse
      frame(SRA_CMD_WRITE, 8'h10, 8'h55, 3, 8);
      `CHK(wq.size(), 0)
      u_host.lock(1);
      `CHK(spi_locked, 1'b0)
      u_host.lock(1);
      `CHK(spi_locked, 1'b1)
      u_host.frame_open();
      `CHK(dout_oe, 1'b1)
      u_host.xfer(SRA_CMD_WRITE, 8, rx);
      u_host.xfer(8'h3e, 8, rx);
      u_host.xfer(8'ha1, 8, rx);
      u_host.xfer(8'hb2, 8, rx);
      u_host.xfer(8'hc3, 8, rx);
      u_host.frame_close();
      `CHK(dout_oe, 1'b0)
      `CHK(wq.size(), 3)
      `CHK(wq[0], 16'h3ea1)
      `CHK(wq[1], 16'h3fb2)
      `CHK(wq[2], 16'h00c3)
      wq.delete();
      frame(8'h55, 8'h3e, 8'h11, 3, 8);
      `CHK(wq.size(), 0)
      frame(SRA_CMD_WRITE, 8'h20, 8'h77, 3, 4);
      `CHK(wq.size(), 0)
      frame(SRA_CMD_WRITE, 8'h3e, 8'h00, 2, 8);
      `CHK(wq.size(), 0)
      u_host.frame_open();
      u_host.xfer(SRA_CMD_READ, 8, rx);
      u_host.xfer(8'hff, 8, r1);
      u_host.xfer(8'hff, 8, r2);
      u_host.xfer(8'hff, 8, r3);
      u_host.frame_close();
      `CHK(r1, 8'h9b)
      `CHK(r2, 8'h9a)
      `CHK(r3, 8'ha5)
      `CHK(wq.size(), 0)
      test_done();
   end
endmodule
`default_nettype wire
